// File: include/dc_cal_pkg.sv
package dc_cal_pkg;

  // **********************************
  // Register map
  // **********************************
  localparam logic [7:0] OFS_CTRL1  = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_CODES  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  localparam int C1_DET_R    = 25;
  localparam int C1_DET_C    = 26;
  localparam int C1_OSC_TEST = 29;
  localparam int C2_START    = 5;
  localparam int C2_RANGE_LO = 22;
  localparam int C2_AUTO     = 24;
  localparam int C2_DIV_LO   = 25;
  localparam int C2_CLK_SEL  = 28;
  localparam int C2_TRIM_LO  = 29;
  localparam int CD_Q_LO     = 16;
  localparam int CD_I_LO     = 24;

  // **********************************
  // Reset values
  // **********************************
  localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL2_RESET = 32'h6000_0000;
  localparam logic [7:0]  CODE_HALF   = 8'h80;

  // **********************************
  // Calibration sequencing
  // **********************************
  localparam logic [3:0] CAL_LAST = 4'h8;
  localparam int         DIV_W    = 15;
  localparam logic [8*DIV_W-1:0] RATIO_LUT_DEF = {
    15'h4000, 15'h2000, 15'h1000, 15'h0800,
    15'h0400, 15'h0200, 15'h0100, 15'h0080};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } cal_state_e;

endpackage : dc_cal_pkg

// File: logic/cal_clk_divider.sv
module cal_clk_divider
  import dc_cal_pkg::*;
#(
  parameter logic [8*DIV_W-1:0] RATIO_LUT = RATIO_LUT_DEF
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       src_tick,
  input  wire logic       restart,
  input  wire logic [2:0] ratio_code,
  output logic            div_tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } div_s;

  div_s q;
  div_s d;

  function automatic logic [DIV_W-1:0] ratio_of(input logic [2:0] c);
    ratio_of = RATIO_LUT[c*DIV_W +: DIV_W];
  endfunction : ratio_of

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (restart) begin
      d.cnt = '0;
    end else if (src_tick) begin
      // Compare with >= so a mid-run ratio change never overruns
      if (q.cnt >= ratio_of(ratio_code) - 1'b1) begin
        d.cnt  = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign div_tick = q.tick;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_div_gap: assert property (div_tick |=> (!div_tick) [*8])
    else $error("divided tick repeated too soon");

endmodule : cal_clk_divider

// File: logic/dc_offset_autocal_control.sv
// How it works
// - Clock select bit 1 takes internal oscillator, 0 takes serial clock.
// - Three-bit trim field sets oscillator frequency, 300 kHz to 1.8 MHz.
// - Trim field resets to the 900 kHz code.
// - Oscillator test bit routes the oscillator to the readback pin.
// - Two-bit range field selects DAC full scale 50 to 200 microamps.
// - Automatic source bit set drives DACs from calibration code registers.
// - Correction codes start at half scale, 128.
// - Writing start begins calibration; hardware clears it on completion.
// - Calibration results stay put until a new calibration starts.
// - Two filter bits set detector bandwidth 10 MHz, 10 kHz or 1 kHz.
// - Three-bit divider field divides the calibration clock.
// - Loop converges in nine divided clock cycles.
// - With automatic source off, host-written codes drive the DACs.
module dc_offset_autocal_control
  import dc_cal_pkg::*;
#(
  parameter logic [8*DIV_W-1:0] RATIO_LUT = RATIO_LUT_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        osc_pin,
  input  wire logic        sclk_pin,
  input  wire logic        det_i_high,
  input  wire logic        det_q_high,
  output logic [2:0]       osc_trim,
  output logic [1:0]       correction_dac_range,
  output logic             detector_resistor_ctrl,
  output logic             detector_capacitor_ctrl,
  output logic [7:0]       i_correction_code,
  output logic [7:0]       q_correction_code,
  output logic             cal_busy,
  output logic             readback_out
);

  // **********************************
  // State
  // **********************************
  typedef struct packed {
    cal_state_e  st;
    logic [31:0] ctrl1;
    logic [31:0] ctrl2;
    logic [7:0]  man_i;
    logic [7:0]  man_q;
    logic [7:0]  cal_i;
    logic [7:0]  cal_q;
    logic [2:0]  bidx;
    logic [3:0]  steps;
    logic [2:0]  osc_s;
    logic [2:0]  sclk_s;
    logic [1:0]  deti_s;
    logic [1:0]  detq_s;
    logic        ap_wr;
    logic [7:0]  ap_addr;
    logic [31:0] rdata;
    logic [7:0]  i_dac;
    logic [7:0]  q_dac;
    logic        rb;
  } state_s;

  state_s q;
  state_s d;

  logic src_tick;
  logic div_tick;
  logic start_req;
  logic finishing;
  logic ap_take;

  // **********************************
  // Helpers
  // **********************************
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    case (a)
      OFS_CTRL1:  reg_sel = 4'h1;
      OFS_CTRL2:  reg_sel = 4'h2;
      OFS_CODES:  reg_sel = 4'h4;
      OFS_STATUS: reg_sel = 4'h8;
      default:    reg_sel = 4'h0;
    endcase
  endfunction : reg_sel

  // One successive-approximation step; a high detector means too much code
  function automatic logic [7:0] sar_step(input logic [7:0] c,
                                          input logic [2:0] b,
                                          input logic       hi);
    sar_step = c;
    if (hi) begin
      sar_step[b] = 1'b0;
    end
    if (b != 3'h0) begin
      sar_step[b - 3'h1] = 1'b1;
    end
  endfunction : sar_step

  assign ap_take   = hsel & hready & htrans[1];
  assign src_tick  = q.ctrl2[C2_CLK_SEL] ? (q.osc_s[1] & ~q.osc_s[2])
                                          : (q.sclk_s[1] & ~q.sclk_s[2]);
  assign finishing = (q.st == ST_RUN) & div_tick & (q.steps == CAL_LAST);
  // A start written in the finishing cycle is not lost
  assign start_req = q.ap_wr & (reg_sel(q.ap_addr) == 4'h2)
                   & hwdata[C2_START] & ((q.st == ST_IDLE) | finishing);

  // **********************************
  // Next state
  // **********************************
  always_comb begin
    d = q;
    d.osc_s  = {q.osc_s[1:0], osc_pin};
    d.sclk_s = {q.sclk_s[1:0], sclk_pin};
    d.deti_s = {q.deti_s[0], det_i_high};
    d.detq_s = {q.detq_s[0], det_q_high};

    d.ap_wr = ap_take & hwrite;
    if (ap_take) begin
      d.ap_addr = haddr[7:0];
    end
    if (ap_take & ~hwrite) begin
      case (reg_sel(haddr[7:0]))
        4'h1:    d.rdata = q.ctrl1;
        4'h2:    d.rdata = q.ctrl2;
        4'h4:    d.rdata = {q.i_dac, q.q_dac, 16'h0000};
        4'h8:    d.rdata = {q.cal_i, q.cal_q, 8'h00, q.steps,
                            3'h0, (q.st == ST_RUN)};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    if (q.ap_wr) begin
      case (reg_sel(q.ap_addr))
        4'h1: d.ctrl1 = hwdata;
        4'h2: begin
          d.ctrl2 = hwdata;
          d.ctrl2[C2_START] = q.ctrl2[C2_START];
        end
        4'h4: begin
          d.man_i = hwdata[CD_I_LO +: 8];
          d.man_q = hwdata[CD_Q_LO +: 8];
        end
        default: d.ap_wr = d.ap_wr;
      endcase
    end

    case (q.st)
      ST_IDLE: d.st = ST_IDLE;
      ST_RUN: begin
        if (div_tick & (q.steps != CAL_LAST)) begin
          d.cal_i = sar_step(q.cal_i, q.bidx, q.deti_s[1]);
          d.cal_q = sar_step(q.cal_q, q.bidx, q.detq_s[1]);
          d.bidx  = q.bidx - 3'h1;
          d.steps = q.steps + 4'h1;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    if (start_req) begin
      d.st              = ST_RUN;
      d.ctrl2[C2_START] = 1'b1;
      d.cal_i           = CODE_HALF;
      d.cal_q           = CODE_HALF;
      d.bidx            = 3'h7;
      d.steps           = 4'h0;
    end else if (finishing) begin
      d.st              = ST_IDLE;
      d.ctrl2[C2_START] = 1'b0;
    end

    // Codes move only inside a run, so results hold otherwise
    d.i_dac = q.ctrl2[C2_AUTO] ? q.cal_i : q.man_i;
    d.q_dac = q.ctrl2[C2_AUTO] ? q.cal_q : q.man_q;
    d.rb    = q.ctrl1[C1_OSC_TEST] & q.osc_s[1];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.ctrl1 <= CTRL1_RESET;
      q.ctrl2 <= CTRL2_RESET;
      q.man_i <= CODE_HALF;
      q.man_q <= CODE_HALF;
      q.cal_i <= CODE_HALF;
      q.cal_q <= CODE_HALF;
      q.i_dac <= CODE_HALF;
      q.q_dac <= CODE_HALF;
    end else begin
      q <= d;
    end
  end

  // **********************************
  // Divided calibration clock
  // **********************************
  cal_clk_divider #(
    .RATIO_LUT (RATIO_LUT)
  ) u_div (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .src_tick   (src_tick),
    .restart    (start_req),
    .ratio_code (q.ctrl2[C2_DIV_LO +: 3]),
    .div_tick   (div_tick)
  );

  // **********************************
  // Outputs
  // **********************************
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign hrdata                  = q.rdata;
  assign osc_trim                = q.ctrl2[C2_TRIM_LO +: 3];
  assign correction_dac_range    = q.ctrl2[C2_RANGE_LO +: 2];
  assign detector_resistor_ctrl  = q.ctrl1[C1_DET_R];
  assign detector_capacitor_ctrl = q.ctrl1[C1_DET_C];
  assign i_correction_code       = q.i_dac;
  assign q_correction_code       = q.q_dac;
  assign cal_busy                = (q.st == ST_RUN);
  assign readback_out            = q.rb;

  // **********************************
  // Checks
  // **********************************
  logic [3:0] run_ticks_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_ticks_q <= 4'h0;
    end else if (start_req) begin
      run_ticks_q <= 4'h0;
    end else if ((q.st == ST_RUN) & div_tick) begin
      run_ticks_q <= run_ticks_q + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_start;
    start_req;
  endsequence

  sequence s_loaded;
    (q.st == ST_RUN) && (q.cal_i == CODE_HALF) && (q.cal_q == CODE_HALF);
  endsequence

  a_start_half: assert property (s_start |=> s_loaded)
    else $error("start did not load half scale");
  a_start_held: assert property ((q.st == ST_RUN) |-> q.ctrl2[C2_START])
    else $error("start bit low while running");
  a_done_clears: assert property (finishing && !start_req |=>
      !q.ctrl2[C2_START] && (q.st == ST_IDLE))
    else $error("start bit not cleared at completion");
  a_nine_ticks: assert property (finishing |-> run_ticks_q == 4'h8)
    else $error("run did not end on ninth divided tick");
  a_codes_hold: assert property ((q.st == ST_IDLE) && !start_req
      |=> $stable(q.cal_i) && $stable(q.cal_q))
    else $error("codes changed outside a run");
  a_dac_auto: assert property (q.ctrl2[C2_AUTO] |=>
      i_correction_code == $past(q.cal_i) &&
      q_correction_code == $past(q.cal_q))
    else $error("DAC not fed from calibration codes");
  a_dac_manual: assert property (!q.ctrl2[C2_AUTO] |=>
      i_correction_code == $past(q.man_i) &&
      q_correction_code == $past(q.man_q))
    else $error("DAC not fed from host codes");
  a_readback_osc: assert property (q.ctrl1[C1_OSC_TEST] && q.osc_s[1]
      |=> readback_out)
    else $error("oscillator not routed to readback");

endmodule : dc_offset_autocal_control

// File: testbench/cal_far_model.sv
module cal_far_model (
  input  wire logic       sclk_run,
  input  wire logic [7:0] i_target,
  input  wire logic [7:0] q_target,
  input  wire logic [7:0] i_code,
  input  wire logic [7:0] q_code,
  output logic            osc_pin,
  output logic            sclk_pin,
  output logic            det_i_high,
  output logic            det_q_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // **********************************
  // Clock sources
  // **********************************
  // Oscillator runs free, serial clock only while the host frames
  initial begin
    osc_pin = 1'b0;
    forever #100 osc_pin = ~osc_pin;
  end
  initial begin
    sclk_pin = 1'b0;
    forever #60 sclk_pin = sclk_run ? ~sclk_pin : 1'b0;
  end
  // **********************************
  // Offset detector
  // **********************************
  // LO is taken as always present, so the detector always answers
  assign det_i_high = i_code > i_target;
  assign det_q_high = q_code > q_target;
endmodule : cal_far_model

// File: testbench/tb_top.sv
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dc_cal_pkg::*;
  logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp, osc_pin, sclk_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, correction_dac_range;
  logic [2:0]  hsize, osc_trim;
  logic        det_i_high, det_q_high, detector_resistor_ctrl;
  logic        detector_capacitor_ctrl, cal_busy, readback_out, sclk_run;
  logic [7:0]  i_correction_code, q_correction_code, i_target, q_target;
  int          n_fail, num_checks;
  dc_offset_autocal_control #(.RATIO_LUT({8{15'h0002}})) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .osc_pin(osc_pin), .sclk_pin(sclk_pin),
    .det_i_high(det_i_high), .det_q_high(det_q_high), .osc_trim(osc_trim),
    .correction_dac_range(correction_dac_range),
    .detector_resistor_ctrl(detector_resistor_ctrl),
    .detector_capacitor_ctrl(detector_capacitor_ctrl),
    .i_correction_code(i_correction_code),
    .q_correction_code(q_correction_code), .cal_busy(cal_busy),
    .readback_out(readback_out));
  cal_far_model far_u (
    .sclk_run(sclk_run), .i_target(i_target), .q_target(q_target),
    .i_code(i_correction_code), .q_code(q_correction_code),
    .osc_pin(osc_pin), .sclk_pin(sclk_pin), .det_i_high(det_i_high),
    .det_q_high(det_q_high));
  // **********************************
  // Bus tasks
  // **********************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : xfer
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // **********************************
  // Scenarios
  // **********************************
  task automatic t_reset;
    xfer(1'b0, OFS_CTRL2, 32'h0);
    `CHK("ctrl2", CTRL2_RESET, rd)
    xfer(1'b0, OFS_CODES, 32'h0);
    `CHK("codes", 32'h8080_0000, rd)
    `CHK("trim", 3'h3, osc_trim)
    `CHK("icode", CODE_HALF, i_correction_code)
    xfer(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask : t_reset
  task automatic t_fields;
    xfer(1'b1, OFS_CTRL2, 32'he280_0000);
    cyc(1);
    `CHK("trim", 3'h7, osc_trim)
    `CHK("range", 2'h2, correction_dac_range)
    xfer(1'b1, OFS_CTRL1, 32'h0400_0000);
    cyc(1);
    `CHK("filt_r", 1'b0, detector_resistor_ctrl)
    `CHK("filt_c", 1'b1, detector_capacitor_ctrl)
    xfer(1'b1, OFS_CTRL1, 32'h2200_0000);
    cyc(1);
    `CHK("filt_r", 1'b1, detector_resistor_ctrl)
    rd = 32'h0;
    repeat (40) begin
      cyc(1);
      rd[readback_out === 1'b1] = 1'b1;
    end
    `CHK("rdback_seen", 32'h3, rd)
    xfer(1'b1, OFS_CTRL1, 32'h0);
    cyc(4);
    rd = 32'h0;
    repeat (40) begin
      cyc(1);
      rd[0] = rd[0] | (readback_out !== 1'b0);
    end
    `CHK("rdback_off", 32'h0, rd)
  endtask : t_fields
  task automatic t_manual;
    xfer(1'b1, OFS_CTRL2, 32'h6000_0000);
    xfer(1'b1, OFS_CODES, 32'h5a3c_0000);
    cyc(2);
    `CHK("man_i", 8'h5a, i_correction_code)
    `CHK("man_q", 8'h3c, q_correction_code)
  endtask : t_manual
  task automatic t_cal(input logic osc, md, input logic [7:0] ti, tq);
    int n;
    i_target <= ti; q_target <= tq;
    xfer(1'b1, OFS_CTRL1, {5'h0, {2{md}}, 25'h0});
    xfer(1'b1, OFS_CTRL2, {3'h3, osc, 1'b0, md, md,
                           1'b1, 18'h0, 1'b1, 5'h0});
    cyc(2);
    `CHK("busy", 1'b1, cal_busy)
    if (!osc) begin
      cyc(400);
      `CHK("busy_no_sclk", 1'b1, cal_busy)
      sclk_run <= 1'b1;
    end
    n = 0;
    while (cal_busy === 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    sclk_run <= 1'b0;
    `CHK("done", 1'b1, n < 2000)
    // Nine ticks of two 8-cycle oscillator periods, plus sync latency
    if (osc) `CHK("dur", 1'b1, n >= 132 && n <= 148)
    cyc(2);
    `CHK("cal_i", ti, i_correction_code)
    `CHK("cal_q", tq, q_correction_code)
    xfer(1'b0, OFS_CTRL2, 32'h0);
    `CHK("start_clr", 1'b0, rd[C2_START])
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", {ti, tq, 8'h00, 4'h8, 4'h0}, rd)
    i_target <= ~ti;
    cyc(300);
    `CHK("kept_i", ti, i_correction_code)
  endtask : t_cal
  task automatic t_rst_mid;
    xfer(1'b1, OFS_CTRL2, 32'h7100_0020);
    cyc(20);
    `CHK("busy_pre", 1'b1, cal_busy)
    // Reset lands off the clock edge, in the middle of a run
    arst_n <= 1'b0;
    cyc(2);
    `CHK("busy_rst", 1'b0, cal_busy)
    `CHK("icode_rst", CODE_HALF, i_correction_code)
    `CHK("trim_rst", 3'h3, osc_trim)
    arst_n <= 1'b1;
    cyc(2);
    xfer(1'b0, OFS_CTRL2, 32'h0);
    `CHK("ctrl2_rst", CTRL2_RESET, rd)
  endtask : t_rst_mid
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // **********************************
  // Main sequence
  // **********************************
  initial begin
    n_fail = 0; num_checks = 0; arst_n = 1'b0; hsel = 1'b0;
    haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = 32'h0; sclk_run = 1'b0; i_target = 8'h40; q_target = 8'h40;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset;
    t_fields;
    t_manual;
    t_cal(1'b1, 1'b0, 8'h9d, 8'h27);
    t_rst_mid;
    t_cal(1'b0, 1'b1, 8'h00, 8'hff);
    summarize;
  end
  initial begin
    #300us;
    n_fail++;
    summarize;
  end
endmodule : tb_top
